// [logic/byte_subtract_xor_swap_alu.sv]
/*
 * Eight-bit execution datapath: subtract from literal or file register,
 * xor with file register or literal, nibble swap, with carry, digit carry
 * and zero flags and a working-register / file-register destination.
 * Reached over AXI4-Lite; writing the command word executes one operation.
 * Assumes a single AXI4-Lite master on aclk; no address crossing needed.
 */
`timescale 1ns/1ps
`default_nettype none
`include "alu_cfg.svh"

module byte_subtract_xor_swap_alu (
    input  wire logic                   aclk,     // Core clock, 50 MHz
    input  wire logic                   aresetn,  // Sync reset, active low
    input  wire logic                   awvalid,  // Write address valid
    output logic                        awready,  // Write address ready
    input  wire logic [`ALU_ADDR_W-1:0] awaddr,   // Write address
    input  wire logic                   wvalid,   // Write data valid
    output logic                        wready,   // Write data ready
    input  wire logic [31:0]            wdata,    // Write data
    input  wire logic [3:0]             wstrb,    // Byte lane strobes
    output logic                        bvalid,   // Write response valid
    input  wire logic                   bready,   // Write response ready
    output logic      [1:0]             bresp,    // Write response code
    input  wire logic                   arvalid,  // Read address valid
    output logic                        arready,  // Read address ready
    input  wire logic [`ALU_ADDR_W-1:0] araddr,   // Read address
    output logic                        rvalid,   // Read data valid
    input  wire logic                   rready,   // Read data ready
    output logic      [31:0]            rdata,    // Read data
    output logic      [1:0]             rresp     // Read response code
);
    alu_pkg::core_state_s st;
    alu_pkg::core_state_s nx;

    logic                  commit_valid;
    alu_pkg::wr_commit_s   commit;
    logic [1:0]            commit_resp;
    alu_pkg::cmd_s         cmd_in;
    logic                  cmd_hit;
    logic                  op_legal;
    logic                  exec;
    logic                  is_sub;
    logic                  is_file_op;
    logic                  to_file;
    logic [7:0]            f_val;
    logic [7:0]            minuend;
    logic [7:0]            sub_diff;
    logic [2:0]            borrow;
    logic [7:0]            alu_result;
    logic [31:0]           rd_word;
    logic [1:0]            rd_resp;

    // Word address of a byte address; low two bits never select
    function automatic logic [`ALU_ADDR_W-1:0] word_of(input logic [`ALU_ADDR_W-1:0] a);
        word_of = {a[`ALU_ADDR_W-1:2], 2'b00};
    endfunction

    // File window lives above the control registers
    function automatic logic in_file(input logic [`ALU_ADDR_W-1:0] a);
        in_file = a[`ALU_FILE_SEL_MSB:`ALU_FILE_SEL_LSB] == `ALU_FILE_SEL;
    endfunction

    function automatic logic is_mapped(input logic [`ALU_ADDR_W-1:0] a);
        is_mapped = in_file(a) || word_of(a) == `ALU_OFF_CMD
                  || word_of(a) == `ALU_OFF_WREG || word_of(a) == `ALU_OFF_STATUS
                  || word_of(a) == `ALU_OFF_RESULT;
    endfunction

    // Write address, write data and response channels
    axi_wr_join u_wr_join (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .awvalid      (awvalid),
        .awready      (awready),
        .awaddr       (awaddr),
        .wvalid       (wvalid),
        .wready       (wready),
        .wdata        (wdata),
        .wstrb        (wstrb),
        .bvalid       (bvalid),
        .bready       (bready),
        .bresp        (bresp),
        .commit_valid (commit_valid),
        .commit       (commit),
        .commit_resp  (commit_resp)
    );

    // Unpack the command word; pad bits forced to zero so readback is clean
    always_comb begin
        cmd_in           = '0;
        cmd_in.op        = alu_pkg::op_e'(commit.data[`ALU_CMD_OP_MSB:`ALU_CMD_OP_LSB]);
        cmd_in.dest      = commit.data[`ALU_CMD_DEST_BIT];
        cmd_in.literal   = commit.data[`ALU_CMD_LIT_MSB:`ALU_CMD_LIT_LSB];
        cmd_in.file_addr = commit.data[`ALU_CMD_FA_MSB:`ALU_CMD_FA_LSB];
    end

    // Opcode classes; codes above the swap are refused with an error answer
    always_comb begin
        op_legal   = 1'b1;
        is_sub     = 1'b0;
        is_file_op = 1'b0;
        unique case (cmd_in.op)
            alu_pkg::subtract_from_literal_op: begin
                is_sub = 1'b1;
            end
            alu_pkg::subtract_from_file_op: begin
                is_sub     = 1'b1;
                is_file_op = 1'b1;
            end
            alu_pkg::xor_with_file_op,
            alu_pkg::nibble_swap_op: begin
                is_file_op = 1'b1;
            end
            alu_pkg::xor_with_literal_op: begin
                op_legal = 1'b1;
            end
            default: begin
                op_legal = 1'b0;
            end
        endcase
    end

    // A command executes only with all three command bytes strobed
    assign cmd_hit     = commit_valid && word_of(commit.addr) == `ALU_OFF_CMD;
    assign commit_resp = (!is_mapped(commit.addr) || (cmd_hit && !op_legal))
                       ? `ALU_RESP_SLVERR : `ALU_RESP_OKAY;
    assign exec        = cmd_hit && op_legal && (&commit.strb[2:0]);
    assign to_file     = is_file_op && cmd_in.dest;

    // Operands: file register by index, literal ops take the literal
    assign f_val   = st.file[cmd_in.file_addr];
    assign minuend = is_file_op ? f_val : cmd_in.literal;

    // Two slices; borrow out of the low slice is the inverted digit carry
    assign borrow[0] = 1'b0;
    for (genvar i = 0; i < 2; i++) begin : g_sub
        nibble_sub #(
            .WIDTH (4)
        ) u_slice (
            .minuend    (minuend[4*i +: 4]),
            .subtrahend (st.w_reg[4*i +: 4]),
            .borrow_in  (borrow[i]),
            .difference (sub_diff[4*i +: 4]),
            .borrow_out (borrow[i+1])
        );
    end

    // Result selection per operation
    always_comb begin
        unique case (cmd_in.op)
            alu_pkg::subtract_from_literal_op,
            alu_pkg::subtract_from_file_op: alu_result = sub_diff;
            alu_pkg::xor_with_file_op:      alu_result = st.w_reg ^ f_val;
            alu_pkg::xor_with_literal_op:   alu_result = st.w_reg ^ cmd_in.literal;
            alu_pkg::nibble_swap_op:        alu_result = {f_val[3:0], f_val[7:4]};
            default:                        alu_result = 8'h00;
        endcase
    end

    // Read decode; unmapped reads give zero data and an error answer
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_resp = `ALU_RESP_OKAY;
        if (in_file(araddr)) begin
            rd_word[7:0] = st.file[araddr[`ALU_FILE_IDX_MSB:`ALU_FILE_IDX_LSB]];
        end else if (word_of(araddr) == `ALU_OFF_CMD) begin
            rd_word = st.last_cmd;
        end else if (word_of(araddr) == `ALU_OFF_WREG) begin
            rd_word[7:0] = st.w_reg;
        end else if (word_of(araddr) == `ALU_OFF_STATUS) begin
            rd_word[`ALU_ST_CARRY_BIT] = st.flags.carry;
            rd_word[`ALU_ST_DC_BIT]    = st.flags.digit_carry_flag;
            rd_word[`ALU_ST_ZERO_BIT]  = st.flags.zero;
        end else if (word_of(araddr) == `ALU_OFF_RESULT) begin
            rd_word[7:0]               = st.result;
            rd_word[`ALU_RES_DEST_BIT] = st.result_to_file;
        end else begin
            rd_resp = `ALU_RESP_SLVERR;
        end
    end

    // Read channel handshakes come straight from the state
    assign arready = st.rd_state == alu_pkg::rd_idle;
    assign rvalid  = st.rd_state == alu_pkg::rd_data;
    assign rdata   = st.rdata;
    assign rresp   = st.rresp;

    // Next state: read channel, software writes, then the execution
    always_comb begin
        nx = st;
        unique case (st.rd_state)
            alu_pkg::rd_idle: begin
                if (arvalid) begin
                    nx.rd_state = alu_pkg::rd_data;
                    nx.rdata    = rd_word;
                    nx.rresp    = rd_resp;
                end
            end
            alu_pkg::rd_data: begin
                if (rready) begin
                    nx.rd_state = alu_pkg::rd_idle;
                end
            end
        endcase
        // Byte lane 0 carries every eight-bit register
        if (commit_valid && commit.strb[0]) begin
            if (word_of(commit.addr) == `ALU_OFF_WREG) begin
                nx.w_reg = commit.data[7:0];
            end
            if (word_of(commit.addr) == `ALU_OFF_STATUS) begin
                nx.flags.carry            = commit.data[`ALU_ST_CARRY_BIT];
                nx.flags.digit_carry_flag = commit.data[`ALU_ST_DC_BIT];
                nx.flags.zero             = commit.data[`ALU_ST_ZERO_BIT];
            end
            if (in_file(commit.addr)) begin
                nx.file[commit.addr[`ALU_FILE_IDX_MSB:`ALU_FILE_IDX_LSB]] = commit.data[7:0];
            end
        end
        if (exec) begin
            nx.last_cmd       = cmd_in;
            nx.result         = alu_result;
            nx.result_to_file = to_file;
            if (to_file) begin
                nx.file[cmd_in.file_addr] = alu_result;
            end else begin
                nx.w_reg = alu_result;
            end
            // No borrow means W did not exceed the minuend
            if (is_sub) begin
                nx.flags.carry            = !borrow[2];
                nx.flags.digit_carry_flag = !borrow[1];
            end
            // Swap leaves every flag alone
            if (cmd_in.op != alu_pkg::nibble_swap_op) begin
                nx.flags.zero = alu_result == 8'h00;
            end
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '{w_reg:          `ALU_W_RST,
                    flags:          `ALU_FLAGS_RST,
                    last_cmd:       `ALU_CMD_RST,
                    result:         8'h00,
                    result_to_file: 1'b0,
                    file:           {`ALU_FILE_DEPTH{`ALU_FILE_RST}},
                    rd_state:       alu_pkg::rd_idle,
                    rdata:          32'h0000_0000,
                    rresp:          `ALU_RESP_OKAY};
        end else begin
            st <= nx;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Subtract from literal lands in W
    a_sublit_result: assert property (
        exec && cmd_in.op == alu_pkg::subtract_from_literal_op
        |=> st.w_reg == 8'($past(cmd_in.literal) - $past(st.w_reg)))
        else $error("literal subtract result wrong");

    a_sublit_flags: assert property (
        exec && cmd_in.op == alu_pkg::subtract_from_literal_op
        |=> st.flags.carry == ($past(st.w_reg) <= $past(cmd_in.literal))
            && st.flags.digit_carry_flag == ($past(st.w_reg[3:0]) <= $past(cmd_in.literal[3:0])))
        else $error("literal subtract flags wrong");

    a_subfile_result: assert property (
        exec && cmd_in.op == alu_pkg::subtract_from_file_op
        |=> st.result == 8'($past(f_val) - $past(st.w_reg)))
        else $error("file subtract result wrong");

    a_subfile_flags: assert property (
        exec && cmd_in.op == alu_pkg::subtract_from_file_op
        |=> st.flags.carry == ($past(st.w_reg) <= $past(f_val))
            && st.flags.digit_carry_flag == ($past(st.w_reg[3:0]) <= $past(f_val[3:0])))
        else $error("file subtract flags wrong");

    a_dest_file: assert property (
        exec && is_file_op && cmd_in.dest
        |=> st.file[$past(cmd_in.file_addr)] == st.result && $stable(st.w_reg))
        else $error("file destination not honoured");

    a_dest_w: assert property (
        exec && is_file_op && !cmd_in.dest
        |=> st.w_reg == st.result && st.file[$past(cmd_in.file_addr)] == $past(f_val))
        else $error("working destination not honoured");

    a_xorfile_only_z: assert property (
        exec && cmd_in.op == alu_pkg::xor_with_file_op
        |=> st.result == ($past(st.w_reg) ^ $past(f_val))
            && $stable(st.flags.carry) && $stable(st.flags.digit_carry_flag))
        else $error("file xor wrong or touched carries");

    a_swap_data: assert property (
        exec && cmd_in.op == alu_pkg::nibble_swap_op
        |=> st.result == {$past(f_val[3:0]), $past(f_val[7:4])})
        else $error("nibble swap wrong");

    a_xorlit_w: assert property (
        exec && cmd_in.op == alu_pkg::xor_with_literal_op
        |=> st.w_reg == ($past(st.w_reg) ^ $past(cmd_in.literal))
            && $stable(st.flags.carry) && $stable(st.flags.digit_carry_flag))
        else $error("literal xor wrong or touched carries");

    a_swap_flags: assert property (
        exec && cmd_in.op == alu_pkg::nibble_swap_op |=> $stable(st.flags))
        else $error("nibble swap changed a flag");

    a_zero_flag: assert property (
        exec && cmd_in.op != alu_pkg::nibble_swap_op |=> st.flags.zero == (st.result == 8'h00))
        else $error("zero flag disagrees with result");

    a_read_answer: assert property (arvalid && arready |=> rvalid ##0 rresp == $past(rd_resp))
        else $error("read answer missing");

    c_sub_zero: cover property (exec && is_sub ##1 st.flags.zero && st.flags.carry);
    c_borrow: cover property (exec && is_sub ##1 !st.flags.carry);
    c_swap_file: cover property (exec && cmd_in.op == alu_pkg::nibble_swap_op && cmd_in.dest);
    c_bad_op: cover property (cmd_hit && !op_legal);
endmodule

`default_nettype wire

// [logic/alu_cfg.svh]
/*
 * Constants of the byte subtract / xor / swap datapath: register offsets,
 * field positions, reset values and bus answers.
 * Assumes inclusion by bare name from the package and the design files.
 */
// Summary of operation
// - Subtract-from-literal writes literal minus working register into the working register.
// - Subtract-from-literal: carry clears when W exceeds literal, digit_carry_flag when W low nibble exceeds literal low nibble.
// - Subtract-from-file computes file register minus W; result to selected destination.
// - Subtract-from-file: carry set when W at most file value, digit_carry_flag when W low nibble at most file low nibble.
// - File operations: destination bit 0 writes W, 1 writes the file register.
// - Xor-with-file xors W with file register; only zero flag changes.
// - Nibble swap exchanges file register nibbles into the destination; flags untouched.
// - Xor-with-literal xors W with literal into W; only zero flag changes.
// - Subtracts update carry, digit carry and zero together; swap changes none.
`ifndef ALU_CFG_SVH
`define ALU_CFG_SVH

`define ALU_ADDR_W        12
`define ALU_FILE_DEPTH    128

// Register offsets (byte addresses)
`define ALU_OFF_CMD       12'h000
`define ALU_OFF_WREG      12'h004
`define ALU_OFF_STATUS    12'h008
`define ALU_OFF_RESULT    12'h00c
`define ALU_FILE_SEL_MSB  11
`define ALU_FILE_SEL_LSB  9
`define ALU_FILE_SEL      3'h1
`define ALU_FILE_IDX_MSB  8
`define ALU_FILE_IDX_LSB  2

// Command word fields
`define ALU_CMD_OP_MSB    2
`define ALU_CMD_OP_LSB    0
`define ALU_CMD_DEST_BIT  7
`define ALU_CMD_LIT_MSB   15
`define ALU_CMD_LIT_LSB   8
`define ALU_CMD_FA_MSB    22
`define ALU_CMD_FA_LSB    16

// Status and result fields
`define ALU_ST_CARRY_BIT  0
`define ALU_ST_DC_BIT     1
`define ALU_ST_ZERO_BIT   2
`define ALU_RES_DEST_BIT  8

// Reset values
`define ALU_W_RST         8'h00
`define ALU_FLAGS_RST     3'h0
`define ALU_FILE_RST      8'h00
`define ALU_CMD_RST       32'h0000_0000

// Bus answers
`define ALU_RESP_OKAY     2'h0
`define ALU_RESP_SLVERR   2'h2

`endif

// [logic/alu_pkg.sv]
/*
 * Types of the byte subtract / xor / swap datapath.
 * Assumes alu_cfg.svh is on the include path.
 */
`include "alu_cfg.svh"

package alu_pkg;

    typedef enum logic [2:0] {
        subtract_from_literal_op = 3'h0,
        subtract_from_file_op    = 3'h1,
        xor_with_file_op         = 3'h2,
        xor_with_literal_op      = 3'h3,
        nibble_swap_op           = 3'h4
    } op_e;

    typedef enum logic [0:0] {
        rd_idle = 1'b0,
        rd_data = 1'b1
    } rd_state_e;

    typedef struct packed {
        logic zero;
        logic digit_carry_flag;
        logic carry;
    } flags_s;

    // Mirrors the command word layout bit for bit
    typedef struct packed {
        logic [8:0] pad_hi;
        logic [6:0] file_addr;
        logic [7:0] literal;
        logic       dest;
        logic [3:0] pad_lo;
        op_e        op;
    } cmd_s;

    typedef struct packed {
        logic [`ALU_ADDR_W-1:0] addr;
        logic [31:0]            data;
        logic [3:0]             strb;
    } wr_commit_s;

    typedef struct packed {
        logic       aw_have;
        logic       w_have;
        logic       bvalid;
        logic [1:0] bresp;
        wr_commit_s commit;
    } join_state_s;

    typedef struct packed {
        logic [7:0]                        w_reg;
        flags_s                            flags;
        cmd_s                              last_cmd;
        logic [7:0]                        result;
        logic                              result_to_file;
        logic [`ALU_FILE_DEPTH-1:0][7:0]   file;
        rd_state_e                         rd_state;
        logic [31:0]                       rdata;
        logic [1:0]                        rresp;
    } core_state_s;

endpackage

// [logic/nibble_sub.sv]
/*
 * One slice of a ripple subtractor: minuend minus subtrahend minus borrow.
 * Assumes the caller chains borrow_out into the next slice's borrow_in.
 */
`timescale 1ns/1ps
`default_nettype none

module nibble_sub #(
    parameter int WIDTH = 4
) (
    input  wire logic [WIDTH-1:0] minuend,     // Value subtracted from
    input  wire logic [WIDTH-1:0] subtrahend,  // Value subtracted
    input  wire logic             borrow_in,   // Borrow from lower slice
    output logic      [WIDTH-1:0] difference,  // Slice difference
    output logic                  borrow_out   // Borrow to upper slice
);
    logic [WIDTH:0] full;

    // Extra top bit catches the borrow
    assign full       = {1'b0, minuend} - {1'b0, subtrahend} - {{WIDTH{1'b0}}, borrow_in};
    assign difference = full[WIDTH-1:0];
    assign borrow_out = full[WIDTH];
endmodule

`default_nettype wire

// [logic/axi_wr_join.sv]
/*
 * AXI4-Lite write side: takes write address and write data in either order,
 * offers one commit when both are held, then answers on the response channel.
 * Assumes the owner returns the response code combinationally with the commit.
 */
`timescale 1ns/1ps
`default_nettype none
`include "alu_cfg.svh"

module axi_wr_join (
    input  wire logic                   aclk,         // Core clock
    input  wire logic                   aresetn,      // Sync reset, active low
    input  wire logic                   awvalid,      // Write address valid
    output logic                        awready,      // Write address ready
    input  wire logic [`ALU_ADDR_W-1:0] awaddr,       // Write address
    input  wire logic                   wvalid,       // Write data valid
    output logic                        wready,       // Write data ready
    input  wire logic [31:0]            wdata,        // Write data
    input  wire logic [3:0]             wstrb,        // Byte lane strobes
    output logic                        bvalid,       // Write response valid
    input  wire logic                   bready,       // Write response ready
    output logic      [1:0]             bresp,        // Write response code
    output logic                        commit_valid, // Write performed now
    output alu_pkg::wr_commit_s         commit,       // Held address and data
    input  wire logic [1:0]             commit_resp   // Answer for the commit
);
    alu_pkg::join_state_s st;
    alu_pkg::join_state_s nx;

    // One slot per channel; a pending response blocks the next commit
    assign awready      = !st.aw_have;
    assign wready       = !st.w_have;
    assign commit_valid = st.aw_have && st.w_have && !st.bvalid;
    assign commit       = st.commit;
    assign bvalid       = st.bvalid;
    assign bresp        = st.bresp;

    // Next state of both slots and the response
    always_comb begin
        nx = st;
        if (awvalid && !st.aw_have) begin
            nx.aw_have     = 1'b1;
            nx.commit.addr = awaddr;
        end
        if (wvalid && !st.w_have) begin
            nx.w_have      = 1'b1;
            nx.commit.data = wdata;
            nx.commit.strb = wstrb;
        end
        if (commit_valid) begin
            nx.aw_have = 1'b0;
            nx.w_have  = 1'b0;
            nx.bvalid  = 1'b1;
            nx.bresp   = commit_resp;
        end else if (st.bvalid && bready) begin
            nx.bvalid = 1'b0;
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_write_answer: assert property (commit_valid |=> bvalid && bresp == $past(commit_resp))
        else $error("write response missing after commit");
    a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before bready");
endmodule

`default_nettype wire

// [testbench/decode_side.sv]
/*
 * Decode-side model: the AXI4-Lite master in front of the datapath.
 * Assumes the bench calls wr and rd one at a time on a free-running aclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "alu_cfg.svh"

module decode_side (
    input  wire logic aclk,    // Core clock
    input  wire logic aresetn, // Sync reset, active low
    output logic      hang     // A handshake wait ran out
);
    logic                   awvalid, awready, wvalid, wready, bvalid, bready;
    logic                   arvalid, arready, rvalid, rready;
    logic [`ALU_ADDR_W-1:0] awaddr, araddr;
    logic [31:0]            wdata, rdata;
    logic [3:0]             wstrb;
    logic [1:0]             bresp, rresp;

    // Quiet bus from time zero
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, hang} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
    end

    byte_subtract_xor_swap_alu i_byte_subtract_xor_swap_alu (.aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

    // Ready is sampled mid-cycle, since it only moves at a rising edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_t, w_t, b_t;
        r = 2'h3;
        b_t = 1'b0;
        @(posedge aclk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= a;
        wdata <= d;
        bready <= 1'b1;
        for (int n = 0; n < 64 && !b_t; n++) begin
            @(negedge aclk);
            aw_t = awvalid && awready;
            w_t = wvalid && wready;
            b_t = bvalid;
            r = b_t ? bresp : r;
            @(posedge aclk);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
            if (b_t) bready <= 1'b0;
        end
        if (!b_t) hang <= 1'b1;
    endtask

    // Read: address held until taken, rready held until the answer
    task automatic rd(input logic [11:0] a);
        logic ar_t, v_t;
        v_t = 1'b0;
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        for (int n = 0; n < 64 && !v_t; n++) begin
            @(negedge aclk);
            ar_t = arvalid && arready;
            v_t = rvalid;
            @(posedge aclk);
            if (ar_t) arvalid <= 1'b0;
            if (v_t) rready <= 1'b0;
        end
        if (!v_t) hang <= 1'b1;
    endtask
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
/*
 * Bench of the byte datapath: random operand sets through all five operations.
 * Assumes decode_side and the design files are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "alu_cfg.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
    $display("[FAIL] %0t value mismatch", $time); end end

module tb_top;
    logic        aclk, aresetn, hang;
    logic [31:0] seed;
    logic [33:0] exp_q [$];
    int          err_total, checks;

    decode_side i_decode_side (.aclk(aclk), .aresetn(aresetn), .hang(hang));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Oldest note against each read answer
    always @(posedge aclk) begin
        if (i_decode_side.rvalid && i_decode_side.rready) begin
            `CHK({i_decode_side.rresp, i_decode_side.rdata}, exp_q.pop_front())
        end
    end

    task automatic rdx(input logic [11:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        i_decode_side.rd(a);
    endtask

    task automatic wrx(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
        logic [1:0] r;
        i_decode_side.wr(a, d, r);
        `CHK(r, e)
    endtask

    // Equal operands forced now and then, the carry and zero boundary
    task automatic run_op(input logic [2:0] op);
        logic [31:0] v, u;
        logic [7:0]  w, f, k, r;
        logic [6:0]  fa;
        logic [2:0]  st, fl;
        logic        d, tf;
        v = rnd();
        u = rnd();
        {d, fa, k, f, w} = v;
        st = u[2:0];
        if (u[5:4] == 2'h0) w = (op == 3'h0) ? k : f;
        fl = st;
        tf = 1'b0;
        case (op)
            3'h0: begin r = k - w; fl = {r == 8'h00, w[3:0] <= k[3:0], w <= k}; end
            3'h1: begin r = f - w; fl = {r == 8'h00, w[3:0] <= f[3:0], w <= f}; tf = d; end
            3'h2: begin r = w ^ f; fl[2] = (r == 8'h00); tf = d; end
            3'h3: begin r = w ^ k; fl[2] = (r == 8'h00); end
            default: begin r = {f[3:0], f[7:4]}; tf = d; end
        endcase
        wrx({3'h1, fa, 2'h0}, {24'h0, f}, 2'h0);
        wrx(`ALU_OFF_WREG, {24'h0, w}, 2'h0);
        wrx(`ALU_OFF_STATUS, {29'h0, st}, 2'h0);
        wrx(`ALU_OFF_CMD, {u[31:23], fa, k, d, u[11:8], op}, 2'h0);
        rdx(`ALU_OFF_CMD, {11'h0, fa, k, d, 4'h0, op});
        rdx(`ALU_OFF_RESULT, {25'h0, tf, r});
        rdx(`ALU_OFF_STATUS, {31'h0, fl});
        rdx(`ALU_OFF_WREG, {26'h0, tf ? w : r});
        rdx({3'h1, fa, 2'h0}, {26'h0, tf ? r : f});
    endtask

    task automatic tally_and_finish();
        $display("TB: errors %0d checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // A stuck handshake ends the run at once
    initial begin
        wait (hang === 1'b1);
        err_total++;
        tally_and_finish();
    end

    // Reset, reset values, all codes, then a refused code and a hole
    initial begin
        aresetn = 1'b0;
        seed = 32'h009f;
        err_total = 0;
        checks = 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rdx(`ALU_OFF_WREG, 34'h0);
        rdx(`ALU_OFF_STATUS, 34'h0);
        for (int i = 0; i < 40; i++) begin
            run_op(3'(i % 5));
        end
        wrx(`ALU_OFF_WREG, 32'h0000_005a, 2'h0);
        wrx(`ALU_OFF_CMD, 32'h0000_ff05, 2'h2);
        // Command without its upper byte lanes must not execute
        i_decode_side.wstrb <= 4'h1;
        wrx(`ALU_OFF_CMD, 32'h0000_ff03, 2'h0);
        rdx(`ALU_OFF_WREG, {26'h0, 8'h5a});
        rdx(12'h100, {2'h2, 32'h0});
        repeat (4) @(posedge aclk);
        `CHK(exp_q.size(), 0)
        tally_and_finish();
    end
endmodule
`default_nettype wire
